/* File: rtl/tci_pkg.sv */
// Constants for the timer capture and interrupt unit
package tci_pkg;
  // Register byte offsets on the AXI4-Lite bus
  localparam logic [7:0] OFS_CAPTURE_LOW = 8'h00;
  localparam logic [7:0] OFS_CAPTURE_HIGH = 8'h04;
  localparam logic [7:0] OFS_IRQ_MASK = 8'h08;
  localparam logic [7:0] OFS_IRQ_FLAGS = 8'h0c;
  localparam logic [7:0] OFS_CONTROL = 8'h10;
  localparam logic [7:0] OFS_IRQ_CLEAR = 8'h14;
  // Bit positions in mask and flag registers
  localparam int BIT_CAPTURE = 5;
  localparam int BIT_OVERFLOW = 0;
  localparam logic [7:0] IRQ_USED_BITS = 8'h21;
  // Bit positions in the control register
  localparam int BIT_FILTER_EN = 7;
  localparam int BIT_EDGE_SEL = 6;
  localparam int BIT_WAVE_MODE = 4;
  // Values after reset
  localparam logic [7:0] RESET_MASK = 8'h00;
  localparam logic [15:0] RESET_CAPTURE = 16'h0000;
  localparam logic [15:0] COUNT_MAX = 16'hffff;
  // Noise filter sample count
  localparam int FILTER_SAMPLES = 4;
  // AXI responses
  localparam logic [1:0] RESP_OKAY = 2'b00;
  localparam logic [1:0] RESP_SLVERR = 2'b10;
endpackage : tci_pkg

/* File: rtl/tci_noise_filter.sv */
// Capture input noise filter: output follows only after equal samples
`timescale 1ns/100ps
module tci_noise_filter (
  input wire logic i_clock,
  input wire logic i_reset_n,
  input wire logic i_enable,
  input wire logic i_sample,
  output logic o_level
);
  typedef struct packed {
    logic [tci_pkg::FILTER_SAMPLES-1:0] hist;
    logic level;
  } tci_filter_state_type;

  tci_filter_state_type state_q;
  tci_filter_state_type state_d;

  // Shift in samples, change level only on a full run of equal ones
  always_comb
  begin
    state_d = state_q;
    state_d.hist = {state_q.hist[tci_pkg::FILTER_SAMPLES-2:0], i_sample};
    if (!i_enable)
    begin
      state_d.level = i_sample;
    end
    else if (&state_q.hist)
    begin
      state_d.level = 1'b1; // [RULE13]
    end
    else if (~|state_q.hist)
    begin
      state_d.level = 1'b0; // [RULE13]
    end
  end

  // State register
  always_ff @(posedge i_clock or negedge i_reset_n)
  begin
    if (!i_reset_n)
    begin
      state_q <= '0;
    end
    else
    begin
      state_q <= state_d;
    end
  end

  assign o_level = state_q.level;

  chk_filter_holds_level: assert property (@(posedge i_clock) disable iff (!i_reset_n) // [RULE13]
    i_enable && $past(i_enable) && (state_q.level != $past(state_q.level))
      |-> (state_q.level == $past(state_q.hist[0])) && ($past(state_q.hist) == {4{state_q.level}}))
    else $error("filter level changed without four equal samples");
endmodule : tci_noise_filter

/* File: rtl/tci_capture_unit.sv */
// Timer input capture, interrupt mask and flag logic with AXI4-Lite access
`timescale 1ns/100ps
// Behaviour
// RULE1: Capture event copies count into capture register
// RULE2: Capture register is top in wave mode
// RULE3: 16-bit capture bytes pass shared high latch
// RULE4: Capture irq when enabled, global, flag set
// RULE5: Overflow irq when enabled, global, flag set
// RULE6: Unused mask and flag bits read zero
// RULE7: Capture event sets capture flag bit five
// RULE8: In wave mode, reaching top sets flag
// RULE9: Vector or write-one clears capture flag
// RULE10: Vector or write-one clears overflow flag
// RULE11: Overflow flag set on wrap from max
// RULE12: Edge select: zero falling, one rising
// RULE13: Filter needs four equal samples to change
// RULE14: Wave mode disconnects the capture pin
// RULE15: Software reads low byte before high byte
module tci_capture_unit (
  input wire logic i_clock,
  input wire logic i_reset_n,
  input wire logic [7:0] i_awaddr,
  input wire logic i_awvalid,
  output logic o_awready,
  input wire logic [31:0] i_wdata,
  input wire logic [3:0] i_wstrb,
  input wire logic i_wvalid,
  output logic o_wready,
  output logic [1:0] o_bresp,
  output logic o_bvalid,
  input wire logic i_bready,
  input wire logic [7:0] i_araddr,
  input wire logic i_arvalid,
  output logic o_arready,
  output logic [31:0] o_rdata,
  output logic [1:0] o_rresp,
  output logic o_rvalid,
  input wire logic i_rready,
  input wire logic i_capture_pin,
  input wire logic i_comparator_out,
  input wire logic i_use_comparator,
  input wire logic [15:0] i_count_value,
  input wire logic i_timer_tick,
  input wire logic i_global_irq_en,
  input wire logic i_capture_vector_ack,
  input wire logic i_overflow_vector_ack,
  output logic [15:0] o_count_top,
  output logic o_capture_irq,
  output logic o_overflow_irq,
  output logic o_irq
);
  typedef struct packed {
    logic [1:0] sync;
    logic filt_prev;
    logic [15:0] capture;
    logic [7:0] temp;
    logic [7:0] mask;
    logic cap_flag;
    logic ovf_flag;
    logic filter_en;
    logic edge_sel;
    logic wave_mode;
    logic [15:0] top;
    logic cap_irq;
    logic ovf_irq;
    logic irq;
    logic aw_got;
    logic [7:0] aw_addr;
    logic w_got;
    logic [7:0] wdata;
    logic wstrb0;
    logic awready;
    logic wready;
    logic bvalid;
    logic [1:0] bresp;
    logic arready;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
  } tci_state_type;

  tci_state_type state_q;
  tci_state_type state_d;
  logic filt_level;
  logic src_level;
  logic cap_event;
  logic top_event;
  logic ovf_event;
  logic write_fire;
  logic read_fire;
  logic [7:0] rd_byte;
  logic rd_ok;
  logic wr_ok;

  // Source select before filtering
  assign src_level = i_use_comparator ? i_comparator_out : state_q.sync[1];

  tci_noise_filter u_filter (
    .i_clock(i_clock),
    .i_reset_n(i_reset_n),
    .i_enable(state_q.filter_en),
    .i_sample(src_level),
    .o_level(filt_level)
  );

  // Event detection on the filtered input and the counter
  always_comb
  begin
    cap_event = 1'b0;
    if (!state_q.wave_mode) // [RULE14]
    begin
      cap_event = state_q.edge_sel ? (filt_level & ~state_q.filt_prev)
                                   : (~filt_level & state_q.filt_prev); // [RULE12]
    end
    top_event = state_q.wave_mode & i_timer_tick & (i_count_value == state_q.capture); // [RULE8]
    ovf_event = i_timer_tick & (i_count_value == tci_pkg::COUNT_MAX); // [RULE11]
  end

  // Read decode
  always_comb
  begin
    rd_byte = 8'h00;
    rd_ok = 1'b1;
    unique case (i_araddr)
      tci_pkg::OFS_CAPTURE_LOW: rd_byte = state_q.capture[7:0];
      tci_pkg::OFS_CAPTURE_HIGH: rd_byte = state_q.temp; // [RULE3] [RULE15]
      tci_pkg::OFS_IRQ_MASK: rd_byte = state_q.mask & tci_pkg::IRQ_USED_BITS; // [RULE6]
      tci_pkg::OFS_IRQ_FLAGS: rd_byte = {2'b00, state_q.cap_flag, 4'h0, state_q.ovf_flag}; // [RULE6]
      tci_pkg::OFS_CONTROL:
      begin
        rd_byte[tci_pkg::BIT_FILTER_EN] = state_q.filter_en;
        rd_byte[tci_pkg::BIT_EDGE_SEL] = state_q.edge_sel;
        rd_byte[tci_pkg::BIT_WAVE_MODE] = state_q.wave_mode;
      end
      tci_pkg::OFS_IRQ_CLEAR: rd_byte = 8'h00;
      default: rd_ok = 1'b0;
    endcase
  end

  // Write decode validity
  always_comb
  begin
    unique case (state_q.aw_addr)
      tci_pkg::OFS_CAPTURE_LOW, tci_pkg::OFS_CAPTURE_HIGH, tci_pkg::OFS_IRQ_MASK,
      tci_pkg::OFS_IRQ_FLAGS, tci_pkg::OFS_CONTROL, tci_pkg::OFS_IRQ_CLEAR: wr_ok = 1'b1;
      default: wr_ok = 1'b0;
    endcase
  end

  assign write_fire = state_q.aw_got & state_q.w_got & ~state_q.bvalid;
  assign read_fire = i_arvalid & state_q.arready;

  // Next state: bus handshakes, register effects and flags
  always_comb
  begin
    logic clr_cap;
    logic clr_ovf;
    clr_cap = i_capture_vector_ack; // [RULE9]
    clr_ovf = i_overflow_vector_ack; // [RULE10]
    state_d = state_q;
    state_d.sync = {state_q.sync[0], i_capture_pin};
    state_d.filt_prev = filt_level;
    // Address and data channels taken in either order
    if (i_awvalid && state_q.awready)
    begin
      state_d.aw_got = 1'b1;
      state_d.aw_addr = i_awaddr;
    end
    if (i_wvalid && state_q.wready)
    begin
      state_d.w_got = 1'b1;
      state_d.wdata = i_wdata[7:0];
      state_d.wstrb0 = i_wstrb[0];
    end
    if (state_q.bvalid && i_bready)
    begin
      state_d.bvalid = 1'b0;
    end
    if (state_q.rvalid && i_rready)
    begin
      state_d.rvalid = 1'b0;
    end
    // Read: low byte read latches the high byte
    if (read_fire)
    begin
      state_d.rvalid = 1'b1;
      state_d.rdata = {24'h000000, rd_byte};
      state_d.rresp = rd_ok ? tci_pkg::RESP_OKAY : tci_pkg::RESP_SLVERR;
      if (i_araddr == tci_pkg::OFS_CAPTURE_LOW)
      begin
        state_d.temp = state_q.capture[15:8]; // [RULE3]
      end
    end
    // Write: high byte parks in the latch, low byte commits both
    if (write_fire)
    begin
      state_d.aw_got = 1'b0;
      state_d.w_got = 1'b0;
      state_d.bvalid = 1'b1;
      state_d.bresp = wr_ok ? tci_pkg::RESP_OKAY : tci_pkg::RESP_SLVERR;
      if (state_q.wstrb0)
      begin
        unique case (state_q.aw_addr)
          tci_pkg::OFS_CAPTURE_LOW: state_d.capture = {state_q.temp, state_q.wdata}; // [RULE3]
          tci_pkg::OFS_CAPTURE_HIGH: state_d.temp = state_q.wdata; // [RULE3]
          tci_pkg::OFS_IRQ_MASK: state_d.mask = state_q.wdata & tci_pkg::IRQ_USED_BITS; // [RULE6]
          tci_pkg::OFS_IRQ_FLAGS, tci_pkg::OFS_IRQ_CLEAR:
          begin
            clr_cap = clr_cap | state_q.wdata[tci_pkg::BIT_CAPTURE]; // [RULE9]
            clr_ovf = clr_ovf | state_q.wdata[tci_pkg::BIT_OVERFLOW]; // [RULE10]
          end
          tci_pkg::OFS_CONTROL:
          begin
            state_d.filter_en = state_q.wdata[tci_pkg::BIT_FILTER_EN];
            state_d.edge_sel = state_q.wdata[tci_pkg::BIT_EDGE_SEL];
            state_d.wave_mode = state_q.wdata[tci_pkg::BIT_WAVE_MODE];
          end
          default: ;
        endcase
      end
    end
    // Capture wins over a software write in the same cycle
    if (cap_event)
    begin
      state_d.capture = i_count_value; // [RULE1]
    end
    // Flags: set beats clear
    if (clr_cap)
    begin
      state_d.cap_flag = 1'b0;
    end
    if (cap_event || top_event)
    begin
      state_d.cap_flag = 1'b1; // [RULE7] [RULE8]
    end
    if (clr_ovf)
    begin
      state_d.ovf_flag = 1'b0;
    end
    if (ovf_event)
    begin
      state_d.ovf_flag = 1'b1; // [RULE11]
    end
    // Top value and interrupt requests
    state_d.top = state_d.wave_mode ? state_d.capture : tci_pkg::COUNT_MAX; // [RULE2]
    state_d.cap_irq = state_d.cap_flag & state_d.mask[tci_pkg::BIT_CAPTURE] & i_global_irq_en; // [RULE4]
    state_d.ovf_irq = state_d.ovf_flag & state_d.mask[tci_pkg::BIT_OVERFLOW] & i_global_irq_en; // [RULE5]
    state_d.irq = state_d.cap_irq | state_d.ovf_irq;
    // Ready signals
    state_d.awready = ~state_d.aw_got & ~state_d.bvalid;
    state_d.wready = ~state_d.w_got & ~state_d.bvalid;
    state_d.arready = ~state_d.rvalid;
  end

  // State register
  always_ff @(posedge i_clock or negedge i_reset_n)
  begin
    if (!i_reset_n)
    begin
      state_q <= '0;
      state_q.mask <= tci_pkg::RESET_MASK;
      state_q.capture <= tci_pkg::RESET_CAPTURE;
      state_q.top <= tci_pkg::COUNT_MAX;
    end
    else
    begin
      state_q <= state_d;
    end
  end

  // Outputs straight from flops
  assign o_awready = state_q.awready;
  assign o_wready = state_q.wready;
  assign o_bresp = state_q.bresp;
  assign o_bvalid = state_q.bvalid;
  assign o_arready = state_q.arready;
  assign o_rdata = state_q.rdata;
  assign o_rresp = state_q.rresp;
  assign o_rvalid = state_q.rvalid;
  assign o_count_top = state_q.top;
  assign o_capture_irq = state_q.cap_irq;
  assign o_overflow_irq = state_q.ovf_irq;
  assign o_irq = state_q.irq;

  // Checks
  chk_capture_load_count: assert property (@(posedge i_clock) disable iff (!i_reset_n) // [RULE1]
    cap_event |=> state_q.capture == $past(i_count_value))
    else $error("capture register did not take the count");
  chk_top_value_sel: assert property (@(posedge i_clock) disable iff (!i_reset_n) // [RULE2]
    o_count_top == (state_q.wave_mode ? state_q.capture : tci_pkg::COUNT_MAX))
    else $error("top value does not follow wave mode");
  chk_latch_high_byte: assert property (@(posedge i_clock) disable iff (!i_reset_n) // [RULE3]
    read_fire && i_araddr == tci_pkg::OFS_CAPTURE_LOW && !write_fire
      |=> state_q.temp == $past(state_q.capture[15:8]))
    else $error("low byte read did not latch high byte");
  chk_capture_irq_req: assert property (@(posedge i_clock) disable iff (!i_reset_n) // [RULE4]
    o_capture_irq == (state_q.cap_flag && state_q.mask[tci_pkg::BIT_CAPTURE] && $past(i_global_irq_en)))
    else $error("capture interrupt request wrong");
  chk_overflow_irq_req: assert property (@(posedge i_clock) disable iff (!i_reset_n) // [RULE5]
    o_overflow_irq == (state_q.ovf_flag && state_q.mask[tci_pkg::BIT_OVERFLOW] && $past(i_global_irq_en)))
    else $error("overflow interrupt request wrong");
  chk_reserved_read_zero: assert property (@(posedge i_clock) disable iff (!i_reset_n) // [RULE6]
    read_fire && (i_araddr == tci_pkg::OFS_IRQ_MASK || i_araddr == tci_pkg::OFS_IRQ_FLAGS)
      |=> (o_rdata & ~{24'h000000, tci_pkg::IRQ_USED_BITS}) == 32'h00000000)
    else $error("reserved bits read non-zero");
  chk_capture_flag_set: assert property (@(posedge i_clock) disable iff (!i_reset_n) // [RULE7]
    cap_event |=> state_q.cap_flag && o_capture_irq == (state_q.mask[tci_pkg::BIT_CAPTURE] && $past(i_global_irq_en)))
    else $error("capture event did not set flag");
  chk_top_flag_set: assert property (@(posedge i_clock) disable iff (!i_reset_n) // [RULE8]
    state_q.wave_mode && i_timer_tick && i_count_value == state_q.capture |=> state_q.cap_flag)
    else $error("top match did not set capture flag");
  chk_capture_flag_clear: assert property (@(posedge i_clock) disable iff (!i_reset_n) // [RULE9]
    i_capture_vector_ack && !cap_event && !top_event |=> !state_q.cap_flag)
    else $error("capture flag not cleared");
  chk_overflow_flag_clear: assert property (@(posedge i_clock) disable iff (!i_reset_n) // [RULE10]
    i_overflow_vector_ack && !ovf_event |=> !state_q.ovf_flag)
    else $error("overflow flag not cleared");
  chk_overflow_wrap_set: assert property (@(posedge i_clock) disable iff (!i_reset_n) // [RULE11]
    $rose(state_q.ovf_flag) |-> $past(i_timer_tick) && $past(i_count_value) == tci_pkg::COUNT_MAX)
    else $error("overflow flag set without wrap");
  chk_edge_select: assert property (@(posedge i_clock) disable iff (!i_reset_n) // [RULE12]
    cap_event |-> filt_level == state_q.edge_sel && state_q.filt_prev != state_q.edge_sel)
    else $error("capture on wrong edge");
  chk_pin_disconnect: assert property (@(posedge i_clock) disable iff (!i_reset_n) // [RULE14]
    state_q.wave_mode && !write_fire |=> state_q.capture == $past(state_q.capture))
    else $error("capture register moved while it is top");
  // Flag set paths and request outputs
  chk_overflow_sets_flag: assert property (@(posedge i_clock) disable iff (!i_reset_n) // [RULE11]
    ovf_event |=> state_q.ovf_flag)
    else $error("wrap did not set overflow flag");
  chk_capture_irq_masked: assert property (@(posedge i_clock) disable iff (!i_reset_n) // [RULE4]
    !state_q.mask[tci_pkg::BIT_CAPTURE] |-> !o_capture_irq)
    else $error("capture interrupt while masked");
  chk_irq_output_or: assert property (@(posedge i_clock) disable iff (!i_reset_n) // [RULE5]
    o_irq == (o_capture_irq || o_overflow_irq))
    else $error("combined interrupt does not match sources");
  // Cover scenarios
  cov_capture_event: cover property (@(posedge i_clock) disable iff (!i_reset_n) cap_event ##1 o_capture_irq);
  cov_filtered_capture: cover property (@(posedge i_clock) disable iff (!i_reset_n) cap_event && state_q.filter_en);
  cov_overflow_event: cover property (@(posedge i_clock) disable iff (!i_reset_n) ovf_event ##2 o_overflow_irq);
  cov_top_match: cover property (@(posedge i_clock) disable iff (!i_reset_n) top_event);
  cov_latched_read: cover property (@(posedge i_clock) disable iff (!i_reset_n)
    read_fire && i_araddr == tci_pkg::OFS_CAPTURE_LOW ##[1:20] read_fire && i_araddr == tci_pkg::OFS_CAPTURE_HIGH);
endmodule : tci_capture_unit

/* File: sim/tci_event_source.sv */
// Model of the external event source that drives the capture pin
`timescale 1ns/100ps
module tci_event_source (
  input wire logic i_clock,
  output logic o_capture_pin
);
  initial o_capture_pin = 1'b1;
  // Move the pin to a new level just after a clock edge
  task automatic set_level(input logic lvl);
    @(posedge i_clock);
    o_capture_pin <= lvl;
  endtask : set_level
  // Short excursion to the opposite level, then back
  task automatic glitch(input int cycles);
    @(posedge i_clock);
    o_capture_pin <= ~o_capture_pin;
    repeat (cycles) @(posedge i_clock);
    o_capture_pin <= ~o_capture_pin;
  endtask : glitch
endmodule : tci_event_source

/* File: sim/tci_capture_unit_tb.sv */
// Self-checking testbench for the timer capture and interrupt unit
`timescale 1ns/100ps
`define CHK(got, exp) begin checks_done++; if ((got) !== (exp)) begin err_total++; \
  $display("mismatch at %0t got %h expected %h", $time, got, exp); end end
module tci_capture_unit_tb;
  logic clock = 1'b0, reset_n = 1'b0;
  logic [7:0] awaddr = 8'h00, araddr = 8'h00;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic [31:0] wdata = 32'h0;
  logic [3:0] wstrb = 4'h0;
  logic awready, wready, bvalid, arready, rvalid;
  logic [1:0] bresp, rresp, resp;
  logic [31:0] rdata;
  logic [7:0] rd;
  logic pin, comp = 1'b0, use_comp = 1'b0, tick = 1'b0, gie = 1'b1, cap_ack = 1'b0, ovf_ack = 1'b0;
  logic [15:0] count = 16'h0000, count_top;
  logic cap_irq, ovf_irq, irq;
  int err_total = 0, checks_done = 0, cycles = 0;
  // Clock of 125 MHz
  always #4 clock = ~clock;
  tci_event_source src_u (.i_clock(clock), .o_capture_pin(pin));
  tci_capture_unit dut_u (.i_clock(clock), .i_reset_n(reset_n), .i_awaddr(awaddr), .i_awvalid(awvalid),
    .o_awready(awready), .i_wdata(wdata), .i_wstrb(wstrb), .i_wvalid(wvalid), .o_wready(wready),
    .o_bresp(bresp), .o_bvalid(bvalid), .i_bready(bready), .i_araddr(araddr), .i_arvalid(arvalid),
    .o_arready(arready), .o_rdata(rdata), .o_rresp(rresp), .o_rvalid(rvalid), .i_rready(rready),
    .i_capture_pin(pin), .i_comparator_out(comp), .i_use_comparator(use_comp), .i_count_value(count),
    .i_timer_tick(tick), .i_global_irq_en(gie), .i_capture_vector_ack(cap_ack),
    .i_overflow_vector_ack(ovf_ack), .o_count_top(count_top), .o_capture_irq(cap_irq),
    .o_overflow_irq(ovf_irq), .o_irq(irq));
  // Verdict and end of run
  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", checks_done, err_total);
    if (err_total == 0 && checks_done > 0)
    begin
      $display("SIMULATION PASSED");
    end
    else
    begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : tally_and_finish
  // Hang guard
  always @(posedge clock)
  begin
    cycles++;
    if (cycles == 20000)
    begin
      err_total++;
      tally_and_finish();
    end
  end
  task automatic wait_cycles(input int n);
    repeat (n) @(posedge clock);
  endtask : wait_cycles
  // AXI4-Lite write of one byte into an aligned word
  task automatic axi_write(input logic [7:0] a, input logic [7:0] d, input logic [3:0] s, output logic [1:0] r);
    bit aw_done, w_done;
    aw_done = 0;
    w_done = 0;
    awaddr <= a;
    wdata <= {24'h000000, d};
    wstrb <= s;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    while (!(aw_done && w_done))
    begin
      @(posedge clock);
      if (!aw_done && awready)
      begin
        aw_done = 1;
        awvalid <= 1'b0;
      end
      if (!w_done && wready)
      begin
        w_done = 1;
        wvalid <= 1'b0;
      end
    end
    do @(posedge clock); while (bvalid !== 1'b1);
    r = bresp;
    bready <= 1'b0;
    @(posedge clock);
  endtask : axi_write
  // AXI4-Lite read of one word
  task automatic axi_read(input logic [7:0] a, output logic [7:0] d, output logic [1:0] r);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do @(posedge clock); while (arready !== 1'b1);
    arvalid <= 1'b0;
    while (rvalid !== 1'b1) @(posedge clock);
    d = rdata[7:0];
    r = rresp;
    rready <= 1'b0;
    @(posedge clock);
  endtask : axi_read
  // Register write that expects an OKAY answer
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    axi_write(a, d, 4'h1, resp);
    `CHK(resp, tci_pkg::RESP_OKAY)
  endtask : wr
  // Register read compared with an expected byte
  task automatic rd_chk(input logic [7:0] a, input logic [7:0] e);
    axi_read(a, rd, resp);
    `CHK(resp, tci_pkg::RESP_OKAY)
    `CHK(rd, e)
  endtask : rd_chk
  // Timer tick at a chosen count value
  task automatic tick_at(input logic [15:0] c);
    @(posedge clock);
    count <= c;
    tick <= 1'b1;
    @(posedge clock);
    tick <= 1'b0;
    wait_cycles(3);
  endtask : tick_at
  // One-cycle vector acknowledge
  task automatic ack(input bit ovf);
    @(posedge clock);
    ovf_ack <= ovf;
    cap_ack <= !ovf;
    @(posedge clock);
    ovf_ack <= 1'b0;
    cap_ack <= 1'b0;
    wait_cycles(3);
  endtask : ack
  // Main sequence
  initial
  begin
    wait_cycles(6);
    reset_n <= 1'b1;
    wait_cycles(2);
    rd_chk(tci_pkg::OFS_IRQ_MASK, tci_pkg::RESET_MASK);
    rd_chk(tci_pkg::OFS_IRQ_FLAGS, 8'h00);
    wr(tci_pkg::OFS_IRQ_MASK, 8'hff);
    rd_chk(tci_pkg::OFS_IRQ_MASK, 8'h21);
    // A write with its low byte strobe off changes nothing
    axi_write(tci_pkg::OFS_IRQ_MASK, 8'h00, 4'h0, resp);
    `CHK(resp, tci_pkg::RESP_OKAY)
    rd_chk(tci_pkg::OFS_IRQ_MASK, 8'h21);
    axi_read(8'h18, rd, resp);
    `CHK(resp, tci_pkg::RESP_SLVERR)
    axi_write(8'h1c, 8'h55, 4'h1, resp);
    `CHK(resp, tci_pkg::RESP_SLVERR)
    // Falling edge capture with edge select zero
    count <= 16'h1234;
    src_u.set_level(1'b0);
    wait_cycles(12);
    rd_chk(tci_pkg::OFS_IRQ_FLAGS, 8'h20);
    `CHK(cap_irq, 1'b1)
    `CHK(irq, 1'b1)
    rd_chk(tci_pkg::OFS_CAPTURE_LOW, 8'h34);
    rd_chk(tci_pkg::OFS_CAPTURE_HIGH, 8'h12);
    wr(tci_pkg::OFS_IRQ_FLAGS, 8'h20);
    rd_chk(tci_pkg::OFS_IRQ_FLAGS, 8'h00);
    count <= 16'h5678;
    src_u.set_level(1'b1);
    wait_cycles(12);
    rd_chk(tci_pkg::OFS_IRQ_FLAGS, 8'h00);
    // Rising edge select
    wr(tci_pkg::OFS_CONTROL, 8'h40);
    src_u.set_level(1'b0);
    wait_cycles(12);
    rd_chk(tci_pkg::OFS_IRQ_FLAGS, 8'h00);
    src_u.set_level(1'b1);
    wait_cycles(12);
    rd_chk(tci_pkg::OFS_CAPTURE_LOW, 8'h78);
    rd_chk(tci_pkg::OFS_CAPTURE_HIGH, 8'h56);
    gie <= 1'b0;
    wait_cycles(3);
    `CHK(irq, 1'b0)
    gie <= 1'b1;
    ack(1'b0);
    rd_chk(tci_pkg::OFS_IRQ_FLAGS, 8'h00);
    `CHK(cap_irq, 1'b0)
    // Overflow on wrap, cleared by vector and by the clear register
    tick_at(16'hfffe);
    rd_chk(tci_pkg::OFS_IRQ_FLAGS, 8'h00);
    tick_at(tci_pkg::COUNT_MAX);
    rd_chk(tci_pkg::OFS_IRQ_FLAGS, 8'h01);
    `CHK(ovf_irq, 1'b1)
    `CHK(irq, 1'b1)
    ack(1'b1);
    rd_chk(tci_pkg::OFS_IRQ_FLAGS, 8'h00);
    tick_at(tci_pkg::COUNT_MAX);
    wr(tci_pkg::OFS_IRQ_CLEAR, 8'h01);
    rd_chk(tci_pkg::OFS_IRQ_FLAGS, 8'h00);
    // Comparator as the capture source
    use_comp <= 1'b1;
    count <= 16'h0abc;
    wait_cycles(2);
    comp <= 1'b1;
    wait_cycles(12);
    rd_chk(tci_pkg::OFS_CAPTURE_LOW, 8'hbc);
    use_comp <= 1'b0;
    wr(tci_pkg::OFS_IRQ_FLAGS, 8'h21);
    // Noise filter rejects a three-sample pulse
    wr(tci_pkg::OFS_CONTROL, 8'hc0);
    src_u.set_level(1'b0);
    wait_cycles(15);
    wr(tci_pkg::OFS_IRQ_FLAGS, 8'h21);
    count <= 16'h1111;
    src_u.glitch(3);
    wait_cycles(15);
    rd_chk(tci_pkg::OFS_IRQ_FLAGS, 8'h00);
    src_u.set_level(1'b1);
    wait_cycles(15);
    rd_chk(tci_pkg::OFS_IRQ_FLAGS, 8'h20);
    rd_chk(tci_pkg::OFS_CAPTURE_LOW, 8'h11);
    wr(tci_pkg::OFS_IRQ_FLAGS, 8'h20);
    // Capture register as top value
    wr(tci_pkg::OFS_CAPTURE_HIGH, 8'h00);
    wr(tci_pkg::OFS_CAPTURE_LOW, 8'h40);
    rd_chk(tci_pkg::OFS_CAPTURE_LOW, 8'h40);
    wr(tci_pkg::OFS_CONTROL, 8'h50);
    wait_cycles(2);
    `CHK(count_top, 16'h0040)
    src_u.set_level(1'b0);
    src_u.set_level(1'b1);
    wait_cycles(12);
    rd_chk(tci_pkg::OFS_IRQ_FLAGS, 8'h00);
    rd_chk(tci_pkg::OFS_CAPTURE_LOW, 8'h40);
    tick_at(16'h0040);
    rd_chk(tci_pkg::OFS_IRQ_FLAGS, 8'h20);
    wr(tci_pkg::OFS_CONTROL, 8'h00);
    wait_cycles(2);
    `CHK(count_top, tci_pkg::COUNT_MAX)
    tally_and_finish();
  end
endmodule : tci_capture_unit_tb
